//--- core/csp_core.sv
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "csp_core_regs.svh"
module csp_core #(
   parameter int SEC_W = 1 // sector bits of a data address
) (
   input wire logic mclk, // system clock
   input wire logic rstn, // sync reset, active low
   input wire logic hsel, // ahb select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic [31:0] hrdata, // ahb read data
   output logic hresp, // ahb response
   input wire logic op_go, // alu op strobe
   input wire csp_pkg::csp_op_t op_code, // alu op
   input wire logic [7:0] op_src, // alu memory operand
   input wire logic mv_go, // move strobe
   input wire logic mv_to_mem, // 1 acc to mem, 0 mem to acc
   input wire logic [8:0] mv_addr, // move address
   input wire logic tbl_go, // table read strobe
   input wire logic [8:0] tbl_dst, // table low byte target
   input wire logic wdt_expire, // watchdog timeout pulse
   output logic [8:0] dm_addr, // data memory address
   output logic dm_we, // data memory write
   output logic dm_re, // data memory read
   output logic [7:0] dm_wdata, // data memory write data
   input wire logic [7:0] dm_rdata, // read data, sampled in the cycle dm_re is high
   output logic [15:0] pm_addr, // program memory table address
   output logic pm_req, // table fetch pending
   input wire logic [15:0] pm_rdata, // table word
   input wire logic pm_valid, // table word valid
   output logic pc_jump, // jump pulse
   output logic [7:0] pc_low, // new pc low byte
   output logic pc_dummy, // dummy cycle pulse
   output logic [7:0] acc_out, // working register
   output logic [7:0] flags_out // status register
);
   import csp_pkg::*;

   // storage registers and bus pipeline
   logic [7:0] ptr0_ff, ptr1l_ff, ptr1h_ff, ptr2l_ff, ptr2h_ff;
   logic [7:0] acc_ff, pcl_ff, table_ptr_low_ff, table_ptr_high_ff, table_high_latch_ff, flags_ff;
   logic hready_ff, a_we_ff, a_rd_ff, rd_int_ff, ld_acc_ff, tbl_act_ff;
   logic [3:0] a_ix_ff;
   logic a_ok_ff;
   logic [31:0] hrdata_ff;
   logic [8:0] dm_addr_ff, tbl_dst_ff;
   logic dm_we_ff, dm_re_ff, jump_ff, dummy_ff;
   logic [7:0] dm_wdata_ff, rd_val_ff;
   logic [15:0] pm_addr_ff;

   // register read mux, ports themselves read zero
   function automatic logic [7:0] sreg_rd(input logic [3:0] ix);
      case (ix)
         `CSP_IX_PTR0: sreg_rd = ptr0_ff;
         `CSP_IX_PTR1L: sreg_rd = ptr1l_ff;
         `CSP_IX_PTR1H: sreg_rd = ptr1h_ff;
         `CSP_IX_PTR2L: sreg_rd = ptr2l_ff;
         `CSP_IX_PTR2H: sreg_rd = ptr2h_ff;
         `CSP_IX_ACC: sreg_rd = acc_ff;
         `CSP_IX_PCL: sreg_rd = pcl_ff;
         `CSP_IX_TABLE_PTR_LOW: sreg_rd = table_ptr_low_ff;
         `CSP_IX_TABLE_HIGH_LATCH: sreg_rd = table_high_latch_ff;
         `CSP_IX_TABLE_PTR_HIGH: sreg_rd = table_ptr_high_ff;
         `CSP_IX_FLAGS: sreg_rd = flags_ff;
         default: sreg_rd = `CSP_RST_BYTE;
      endcase
   endfunction

   // map an instruction address to a physical location
   function automatic logic [8:0] resolve(input logic [8:0] a);
      if (a == {5'h00, `CSP_IX_PORT0}) begin
         resolve = {1'b0, ptr0_ff};
      end else if (a == {5'h00, `CSP_IX_PORT1}) begin
         resolve = {ptr1h_ff[SEC_W-1:0], ptr1l_ff};
      end else if (a == {5'h00, `CSP_IX_PORT2}) begin
         resolve = {ptr2h_ff[SEC_W-1:0], ptr2l_ff};
      end else begin
         resolve = a;
      end
   endfunction

   // true when a physical location is held in this block
   function automatic logic is_sreg(input logic [8:0] p);
      is_sreg = (p[8:4] == 5'h00) && (p[3:0] != `CSP_IX_PORT0)
         && (p[3:0] != `CSP_IX_PORT1) && (p[3:0] != `CSP_IX_PORT2)
         && (p[3:0] != 4'hB) && (p[3:0] != 4'hF);
   endfunction

   // ops that leave a result in the working register
   function automatic logic op_writes_acc(input csp_op_t c);
      op_writes_acc = c inside {CSP_OP_ADD, CSP_OP_ADC, CSP_OP_SUB, CSP_OP_SBC, CSP_OP_AND,
         CSP_OP_OR, CSP_OP_XOR, CSP_OP_RLC, CSP_OP_RRC};
   endfunction

   // logical ops, which move only the zero flag
   function automatic logic op_is_logic(input csp_op_t c);
      op_is_logic = (c == CSP_OP_AND) || (c == CSP_OP_OR) || (c == CSP_OP_XOR);
   endfunction

   // system ops that clear the watchdog flag
   function automatic logic op_clears_to(input csp_op_t c);
      op_clears_to = (c == CSP_OP_HALT) || (c == CSP_OP_KICK);
   endfunction

   // ahb address phase decode
   logic a_take;
   assign a_take = hsel & htrans[1] & hready;

   // software write in its data phase
   logic sw_we;
   logic [7:0] sw_d;
   assign sw_we = a_we_ff & a_ok_ff;
   assign sw_d = hwdata[7:0];

   // execution-side write: move from acc or table low byte
   logic ex_we, ex_rd;
   logic [8:0] ex_wp, mv_p;
   logic [7:0] ex_d;
   assign mv_p = resolve(mv_addr);
   assign ex_rd = mv_go & ~mv_to_mem;
   always_comb begin
      ex_we = 1'b0;
      ex_wp = 9'h000;
      ex_d = acc_ff;
      if (tbl_act_ff && pm_valid) begin
         ex_we = 1'b1;
         ex_wp = tbl_dst_ff;
         ex_d = pm_rdata[7:0];
      end else if (mv_go && mv_to_mem) begin
         ex_we = 1'b1;
         ex_wp = mv_p;
         ex_d = acc_ff;
      end
   end

   // per-register write enable, execution side wins
   function automatic logic hit_ex(input logic [3:0] ix);
      hit_ex = ex_we && is_sreg(ex_wp) && (ex_wp[3:0] == ix);
   endfunction
   function automatic logic hit_sw(input logic [3:0] ix);
      hit_sw = sw_we && (a_ix_ff == ix);
   endfunction

   // alu flag computation
   logic is_arith, is_sub, cin;
   logic [7:0] bop, res;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] low7;
   logic ovf;
   always_comb begin
      is_sub = (op_code == CSP_OP_SUB) || (op_code == CSP_OP_SBC);
      is_arith = is_sub || (op_code == CSP_OP_ADD) || (op_code == CSP_OP_ADC);
      bop = is_sub ? ~op_src : op_src;
      case (op_code)
         CSP_OP_SUB: cin = 1'b1;
         CSP_OP_ADC, CSP_OP_SBC: cin = flags_ff[`CSP_B_C];
         default: cin = 1'b0;
      endcase
      sum = {1'b0, acc_ff} + {1'b0, bop} + {8'h00, cin};
      nib = {1'b0, acc_ff[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
      low7 = {1'b0, acc_ff[6:0]} + {1'b0, bop[6:0]} + {7'h00, cin};
      // carry into the msb comes out of the low seven bits
      ovf = low7[7] ^ sum[8];
      case (op_code)
         CSP_OP_AND: res = acc_ff & op_src;
         CSP_OP_OR: res = acc_ff | op_src;
         CSP_OP_XOR: res = acc_ff ^ op_src;
         CSP_OP_RLC: res = {acc_ff[6:0], flags_ff[`CSP_B_C]};
         CSP_OP_RRC: res = {flags_ff[`CSP_B_C], acc_ff[7:1]};
         default: res = sum[7:0];
      endcase
   end

   // ahb slave: writes zero-wait, reads one wait state
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         hready_ff <= 1'b1;
         a_we_ff <= 1'b0;
         a_rd_ff <= 1'b0;
         a_ok_ff <= 1'b0;
         a_ix_ff <= 4'h0;
         hrdata_ff <= 32'h00000000;
      end else begin
         a_we_ff <= a_take & hwrite;
         a_rd_ff <= a_take & ~hwrite;
         hready_ff <= ~(a_take & ~hwrite);
         if (a_take) begin
            a_ix_ff <= haddr[5:2];
            a_ok_ff <= (haddr[31:6] == 26'h0000000);
         end
         // read data phase returns the addressed register
         if (a_rd_ff) begin
            hrdata_ff <= {24'h000000, a_ok_ff ? sreg_rd(a_ix_ff) : 8'h00};
         end
      end
   end

   // memory pointers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ptr0_ff <= `CSP_RST_BYTE;
         ptr1l_ff <= `CSP_RST_BYTE;
         ptr1h_ff <= `CSP_RST_BYTE;
         ptr2l_ff <= `CSP_RST_BYTE;
         ptr2h_ff <= `CSP_RST_BYTE;
      end else begin
         // execution write beats a bus write in the same cycle
         if (hit_ex(`CSP_IX_PTR0)) ptr0_ff <= ex_d;
         else if (hit_sw(`CSP_IX_PTR0)) ptr0_ff <= sw_d;
         if (hit_ex(`CSP_IX_PTR1L)) ptr1l_ff <= ex_d;
         else if (hit_sw(`CSP_IX_PTR1L)) ptr1l_ff <= sw_d;
         if (hit_ex(`CSP_IX_PTR1H)) ptr1h_ff <= ex_d;
         else if (hit_sw(`CSP_IX_PTR1H)) ptr1h_ff <= sw_d;
         if (hit_ex(`CSP_IX_PTR2L)) ptr2l_ff <= ex_d;
         else if (hit_sw(`CSP_IX_PTR2L)) ptr2l_ff <= sw_d;
         if (hit_ex(`CSP_IX_PTR2H)) ptr2h_ff <= ex_d;
         else if (hit_sw(`CSP_IX_PTR2H)) ptr2h_ff <= sw_d;
      end
   end

   // working register: alu result, memory load, or direct write
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         acc_ff <= `CSP_RST_BYTE;
      end else if (op_go && op_writes_acc(op_code)) begin
         acc_ff <= res;
      end else if (ld_acc_ff) begin
         acc_ff <= rd_int_ff ? rd_val_ff : dm_rdata;
      end else if (hit_ex(`CSP_IX_ACC)) begin
         acc_ff <= ex_d;
      end else if (hit_sw(`CSP_IX_ACC)) begin
         acc_ff <= sw_d;
      end
   end

   // table pointers, latch and fetch
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         table_ptr_low_ff <= `CSP_RST_BYTE;
         table_ptr_high_ff <= `CSP_RST_BYTE;
         table_high_latch_ff <= `CSP_RST_BYTE;
         tbl_act_ff <= 1'b0;
         tbl_dst_ff <= 9'h000;
         pm_addr_ff <= 16'h0000;
      end else begin
         if (hit_ex(`CSP_IX_TABLE_PTR_LOW)) table_ptr_low_ff <= ex_d;
         else if (hit_sw(`CSP_IX_TABLE_PTR_LOW)) table_ptr_low_ff <= sw_d;
         if (hit_ex(`CSP_IX_TABLE_PTR_HIGH)) table_ptr_high_ff <= ex_d;
         else if (hit_sw(`CSP_IX_TABLE_PTR_HIGH)) table_ptr_high_ff <= sw_d;
         if (tbl_act_ff && pm_valid) begin
            table_high_latch_ff <= pm_rdata[15:8];
            tbl_act_ff <= 1'b0;
         end else if (hit_ex(`CSP_IX_TABLE_HIGH_LATCH)) begin
            table_high_latch_ff <= ex_d;
         end else if (hit_sw(`CSP_IX_TABLE_HIGH_LATCH)) begin
            table_high_latch_ff <= sw_d;
         end
         // a new fetch is ignored while one is pending
         if (tbl_go && !tbl_act_ff) begin
            tbl_act_ff <= 1'b1;
            pm_addr_ff <= {table_ptr_high_ff, table_ptr_low_ff};
            tbl_dst_ff <= resolve(tbl_dst);
         end
      end
   end

   // pc low byte write gives an in-page jump plus a dummy cycle
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pcl_ff <= `CSP_RST_BYTE;
         jump_ff <= 1'b0;
         dummy_ff <= 1'b0;
      end else begin
         // a pc low write from either side jumps
         jump_ff <= hit_ex(`CSP_IX_PCL) | hit_sw(`CSP_IX_PCL);
         dummy_ff <= jump_ff;
         if (hit_ex(`CSP_IX_PCL)) pcl_ff <= ex_d;
         else if (hit_sw(`CSP_IX_PCL)) pcl_ff <= sw_d;
      end
   end

   // status register; interrupts and calls never save it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         flags_ff <= `CSP_RST_BYTE;
      end else begin
         // direct writes never reach the watchdog and halt flags
         if (hit_ex(`CSP_IX_FLAGS)) begin
            flags_ff[7:6] <= ex_d[7:6];
            flags_ff[3:0] <= ex_d[3:0];
         end else if (hit_sw(`CSP_IX_FLAGS)) begin
            flags_ff[7:6] <= sw_d[7:6];
            flags_ff[3:0] <= sw_d[3:0];
         end
         // flags from the alu op
         if (op_go) begin
            if (is_arith) begin
               flags_ff[`CSP_B_C] <= sum[8];
               flags_ff[`CSP_B_AC] <= nib[4];
               flags_ff[`CSP_B_OV] <= ovf;
               flags_ff[`CSP_B_SC] <= ovf ^ res[7];
            end
            if (op_code == CSP_OP_RLC) flags_ff[`CSP_B_C] <= acc_ff[7];
            if (op_code == CSP_OP_RRC) flags_ff[`CSP_B_C] <= acc_ff[0];
            if (is_arith || op_is_logic(op_code)) begin
               flags_ff[`CSP_B_Z] <= (res == 8'h00);
            end
            if (op_code == CSP_OP_SUB) begin
               flags_ff[`CSP_B_CZ] <= (res == 8'h00);
            end else if (op_code == CSP_OP_SBC) begin
               flags_ff[`CSP_B_CZ] <= flags_ff[`CSP_B_CZ] & (res == 8'h00);
            end
            if (op_code == CSP_OP_HALT) flags_ff[`CSP_B_PDF] <= 1'b1;
            if (op_code == CSP_OP_KICK) flags_ff[`CSP_B_PDF] <= 1'b0;
         end
         // timeout set wins over a kick or halt in the same cycle
         if (wdt_expire) begin
            flags_ff[`CSP_B_TO] <= 1'b1;
         end else if (op_go && op_clears_to(op_code)) begin
            flags_ff[`CSP_B_TO] <= 1'b0;
         end
      end
   end

   // data memory port for locations outside this block
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         dm_addr_ff <= 9'h000;
         dm_we_ff <= 1'b0;
         dm_re_ff <= 1'b0;
         dm_wdata_ff <= 8'h00;
         ld_acc_ff <= 1'b0;
         rd_int_ff <= 1'b0;
         rd_val_ff <= 8'h00;
      end else begin
         dm_we_ff <= ex_we & ~is_sreg(ex_wp);
         dm_re_ff <= ex_rd & ~is_sreg(mv_p);
         // acc picks up the read one edge after the strobe
         ld_acc_ff <= ex_rd;
         rd_int_ff <= is_sreg(mv_p);
         rd_val_ff <= sreg_rd(mv_p[3:0]);
         if (ex_we) begin
            dm_addr_ff <= ex_wp;
            dm_wdata_ff <= ex_d;
         end else if (ex_rd) begin
            dm_addr_ff <= mv_p;
         end
      end
   end

   // outputs
   assign hreadyout = hready_ff;
   assign hrdata = hrdata_ff;
   assign hresp = 1'b0;
   assign dm_addr = dm_addr_ff;
   assign dm_we = dm_we_ff;
   assign dm_re = dm_re_ff;
   assign dm_wdata = dm_wdata_ff;
   assign pm_addr = pm_addr_ff;
   assign pm_req = tbl_act_ff;
   assign pc_jump = jump_ff;
   assign pc_low = pcl_ff;
   assign pc_dummy = dummy_ff;
   assign acc_out = acc_ff;
   assign flags_out = flags_ff;
endmodule

//--- pkg/csp_core_regs.svh
`ifndef CSP_CORE_REGS_SVH
`define CSP_CORE_REGS_SVH
// How it works
// - indirect port access goes to pointed location
// - pointer zero reaches sector 0 only
// - ports one, two use high/low pointer pair
// - extended address: upper bits sector, low offset
// - pointers are real read/write registers
// - every move passes the working register
// - pc low write jumps within page
// - pc low jump inserts one dummy cycle
// - table read: high to latch, low to memory
// - status writes keep watchdog and halt flags
// - carry from add, no-borrow, rotate
// - half carry from low nibble
// - zero flag when result is zero
// - overflow is carry-in xor carry-out msb
// - halt flag: set by halt, cleared kick/reset
// - watchdog flag: set timeout, cleared kick/halt/reset
// - sign-xor is overflow xor result msb
// - subtract copies zero into chained flag
// - subtract-borrow ands zero into chained flag
// - other ops keep chained flag
// - no automatic status save
// - status bit order sc,cz,to,pdf,ov,z,ac,c
// - port register reads 00H, writes ignored
// - extended address carries 9 valid bits

// special register indices, byte address is four times the index
`define CSP_IX_PORT0 4'h0
`define CSP_IX_PTR0 4'h1
`define CSP_IX_PORT1 4'h2
`define CSP_IX_PTR1L 4'h3
`define CSP_IX_PTR1H 4'h4
`define CSP_IX_ACC 4'h5
`define CSP_IX_PCL 4'h6
`define CSP_IX_TABLE_PTR_LOW 4'h7
`define CSP_IX_TABLE_HIGH_LATCH 4'h8
`define CSP_IX_TABLE_PTR_HIGH 4'h9
`define CSP_IX_FLAGS 4'hA
`define CSP_IX_PORT2 4'hC
`define CSP_IX_PTR2L 4'hD
`define CSP_IX_PTR2H 4'hE
// status bit positions
`define CSP_B_SC 7
`define CSP_B_CZ 6
`define CSP_B_TO 5
`define CSP_B_PDF 4
`define CSP_B_OV 3
`define CSP_B_Z 2
`define CSP_B_AC 1
`define CSP_B_C 0
// software-writable status bits
`define CSP_FLAGS_WMASK 8'hCF
`define CSP_RST_BYTE 8'h00
`endif

//--- pkg/csp_pkg.sv
package csp_pkg;
   // operations issued by the execution unit
   typedef enum logic [3:0] {
      CSP_OP_NONE, CSP_OP_ADD, CSP_OP_ADC, CSP_OP_SUB, CSP_OP_SBC,
      CSP_OP_AND, CSP_OP_OR, CSP_OP_XOR, CSP_OP_RLC, CSP_OP_RRC,
      CSP_OP_HALT, CSP_OP_KICK
   } csp_op_t;
endpackage

//--- verif/csp_core_chk.sv
`timescale 1ns/10ps
module csp_chk (
   input wire logic mclk, // clock
   input wire logic rstn, // reset
   input wire logic hsel, // select
   input wire logic [1:0] htrans, // type
   input wire logic hwrite, // write
   input wire logic hready, // ready in
   input wire logic hreadyout, // ready out
   input wire logic hresp, // response
   input wire logic op_go, // op strobe
   input wire csp_pkg::csp_op_t op_code, // op
   input wire logic wdt_expire, // timeout
   input wire logic tbl_go, // table strobe
   input wire logic pm_req, // table pending
   input wire logic pm_valid, // table word
   input wire logic pc_jump, // jump
   input wire logic pc_dummy, // dummy
   input wire logic [7:0] acc_out, // acc
   input wire logic [7:0] flags_out // status
);
   import csp_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // taken bus requests
   wire logic take_rd = hsel & htrans[1] & hready & ~hwrite;
   wire logic take_wr = hsel & htrans[1] & hready & hwrite;
   wire logic arith = op_go & (op_code inside {CSP_OP_ADD, CSP_OP_ADC, CSP_OP_SUB, CSP_OP_SBC});
   wire logic logic_op = op_go & (op_code inside {CSP_OP_AND, CSP_OP_OR, CSP_OP_XOR});
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_read_wait: assert property (take_rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (take_wr |=> hreadyout)
      else $error("write stalled");
   a_dummy_follows: assert property (pc_jump |=> pc_dummy)
      else $error("no dummy after jump");
   a_dummy_cause: assert property (pc_dummy |-> $past(pc_jump))
      else $error("dummy without jump");
   a_expire_sets: assert property (wdt_expire |=> flags_out[5])
      else $error("timeout flag not set");
   a_halt_flags: assert property (op_go && op_code == CSP_OP_HALT && !wdt_expire
      |=> flags_out[5:4] == 2'b01)
      else $error("halt flags wrong");
   a_kick_clears: assert property (op_go && op_code == CSP_OP_KICK && !wdt_expire
      |=> flags_out[5:4] == 2'b00)
      else $error("kick flags wrong");
   a_logic_zero: assert property (logic_op |=> flags_out[2] == (acc_out == 8'h00))
      else $error("zero flag wrong");
   a_sign_xor: assert property (arith |=> flags_out[7] == (flags_out[3] ^ acc_out[7]))
      else $error("sign xor wrong");
   a_sub_chain: assert property (op_go && op_code == CSP_OP_SUB
      |=> flags_out[6] == flags_out[2])
      else $error("chained flag after sub");
   a_sbc_chain: assert property (op_go && op_code == CSP_OP_SBC
      |=> flags_out[6] == ($past(flags_out[6]) & flags_out[2]))
      else $error("chained flag after sbc");
   a_chain_kept: assert property ((arith && op_code inside {CSP_OP_ADD, CSP_OP_ADC})
      || logic_op |=> $stable(flags_out[6]))
      else $error("chained flag changed");
   a_table_hold: assert property (pm_req && !pm_valid |=> pm_req)
      else $error("table request dropped");
   c_jump: cover property (pc_jump ##1 pc_dummy);
   c_sbc: cover property (op_go && op_code == CSP_OP_SBC);
   c_table: cover property (pm_req && pm_valid);
endmodule
bind csp_core csp_chk i_chk (.mclk(mclk), .rstn(rstn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .op_go(op_go),
   .op_code(op_code), .wdt_expire(wdt_expire), .tbl_go(tbl_go), .pm_req(pm_req),
   .pm_valid(pm_valid), .pc_jump(pc_jump), .pc_dummy(pc_dummy), .acc_out(acc_out),
   .flags_out(flags_out));

//--- verif/testbench.sv
`timescale 1ns/10ps
`include "csp_core_regs.svh"
module testbench;
   import csp_pkg::*;
   logic mclk, rstn, hsel, hwrite, op_go, mv_go, mv_to_mem, tbl_go, wdt_expire, pm_valid;
   logic [31:0] haddr, hwdata, rv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   csp_op_t op_code;
   logic [7:0] op_src, dm_rdata, m_acc, m_fl;
   logic [8:0] mv_addr, tbl_dst;
   logic [15:0] pm_rdata;
   wire logic hready, hresp, dm_we, dm_re, pm_req, pc_jump, pc_dummy;
   wire logic [31:0] hrdata;
   wire logic [8:0] dm_addr;
   wire logic [7:0] dm_wdata, pc_low, acc_out, flags_out;
   wire logic [15:0] pm_addr;
   int err_count, total_checks, seed, i;
   logic [7:0] vals [6];
   logic [3:0] ixs [6] = '{`CSP_IX_PTR0, `CSP_IX_PTR1L, `CSP_IX_PTR2L, `CSP_IX_ACC,
      `CSP_IX_TABLE_PTR_LOW, `CSP_IX_TABLE_PTR_HIGH};
   csp_core i_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hrdata(hrdata), .hresp(hresp), .op_go(op_go), .op_code(op_code), .op_src(op_src),
      .mv_go(mv_go), .mv_to_mem(mv_to_mem), .mv_addr(mv_addr), .tbl_go(tbl_go),
      .tbl_dst(tbl_dst), .wdt_expire(wdt_expire), .dm_addr(dm_addr), .dm_we(dm_we),
      .dm_re(dm_re), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .pm_addr(pm_addr),
      .pm_req(pm_req), .pm_rdata(pm_rdata), .pm_valid(pm_valid), .pc_jump(pc_jump),
      .pc_low(pc_low), .pc_dummy(pc_dummy), .acc_out(acc_out), .flags_out(flags_out));
   // free running clock
   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one single ahb transfer, read data left in rv
   task automatic ahb(input logic wr, input logic [3:0] ix, input logic [7:0] wd);
      hwrite <= wr;
      haddr <= {26'h0, ix, 2'h0};
      htrans <= 2'h2;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge mclk); while (hready !== 1'b1);
      rv = hrdata;
   endtask
   task automatic rd(input logic [3:0] ix, input logic [7:0] ex);
      ahb(1'b0, ix, 8'h00);
      chk("hrdata", {24'h0, ex}, rv);
   endtask
   // bounded wait: 0 memory strobe, 1 jump, 2 table request
   task automatic wt(input int k);
      repeat (8) begin
         @(posedge mclk);
         if (k == 0 && (dm_we | dm_re) === 1'b1 || k == 1 && pc_jump === 1'b1) break;
         if (k == 2 && pm_req === 1'b1) break;
      end
   endtask
   // alu op against the flag model
   task automatic op(input csp_op_t c, input logic [7:0] s);
      logic [8:0] r;
      logic [4:0] h;
      logic [7:0] b, r7;
      logic ci;
      op_code <= c;
      op_src <= s;
      op_go <= 1'b1;
      @(posedge mclk);
      op_go <= 1'b0;
      b = (c == CSP_OP_SUB || c == CSP_OP_SBC) ? ~s : s;
      ci = (c == CSP_OP_ADD) ? 1'b0 : (c == CSP_OP_SUB) ? 1'b1 : m_fl[0];
      r = m_acc + b + ci;
      h = m_acc[3:0] + b[3:0] + ci;
      r7 = m_acc[6:0] + b[6:0] + ci;
      case (c)
         CSP_OP_ADD, CSP_OP_ADC, CSP_OP_SUB, CSP_OP_SBC: begin
            m_fl[2:0] = {r[7:0] == 8'h00, h[4], r[8]};
            m_fl[3] = r7[7] ^ r[8];
            m_fl[7] = m_fl[3] ^ r[7];
            if (c == CSP_OP_SUB) m_fl[6] = m_fl[2];
            if (c == CSP_OP_SBC) m_fl[6] = m_fl[6] & m_fl[2];
            m_acc = r[7:0];
         end
         CSP_OP_AND: m_acc = m_acc & s;
         CSP_OP_OR: m_acc = m_acc | s;
         CSP_OP_XOR: m_acc = m_acc ^ s;
         CSP_OP_RLC: {m_fl[0], m_acc} = {m_acc, m_fl[0]};
         CSP_OP_RRC: {m_acc, m_fl[0]} = {m_fl[0], m_acc};
         CSP_OP_HALT: m_fl[5:4] = 2'b01;
         CSP_OP_KICK: m_fl[5:4] = 2'b00;
         default: ;
      endcase
      if (c inside {CSP_OP_AND, CSP_OP_OR, CSP_OP_XOR}) m_fl[2] = (m_acc == 8'h00);
      repeat (2) @(posedge mclk);
      chk("acc_out", {24'h0, m_acc}, {24'h0, acc_out});
      chk("flags_out", {24'h0, m_fl}, {24'h0, flags_out});
   endtask
   task automatic wdt;
      wdt_expire <= 1'b1;
      @(posedge mclk);
      wdt_expire <= 1'b0;
      repeat (2) @(posedge mclk);
      m_fl[5] = 1'b1;
      chk("flags_out", {24'h0, m_fl}, {24'h0, flags_out});
   endtask
   // move between acc and a data location
   task automatic mvt(input logic tm, input logic [8:0] a, input logic [8:0] ea);
      mv_to_mem <= tm;
      mv_addr <= a;
      mv_go <= 1'b1;
      @(posedge mclk);
      mv_go <= 1'b0;
      wt(0);
      chk("dm strobe", {31'h0, 1'b1}, {31'h0, tm ? dm_we : dm_re});
      chk("dm_addr", {23'h0, ea}, {23'h0, dm_addr});
      if (tm) chk("dm_wdata", {24'h0, m_acc}, {24'h0, dm_wdata});
      repeat (2) @(posedge mclk);
   endtask
   initial begin
      #100000;
      err_count++;
      complete_run;
   end
   initial begin
      {rstn, hsel, hwrite, op_go, mv_go, mv_to_mem, tbl_go, wdt_expire, pm_valid} = '0;
      {haddr, hwdata, htrans, op_src, dm_rdata, mv_addr, tbl_dst, pm_rdata} = '0;
      hsize = 3'h2;
      op_code = CSP_OP_NONE;
      seed = 37649;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      hsel <= 1'b1;
      @(posedge mclk);
      m_fl = 8'h00;
      rd(`CSP_IX_FLAGS, 8'h00);
      rd(`CSP_IX_PORT0, 8'h00);
      for (i = 0; i < 6; i++) begin
         vals[i] = 8'($random(seed)) | 8'h40;
         ahb(1'b1, ixs[i], vals[i]);
         rd(ixs[i], vals[i]);
      end
      m_acc = vals[3];
      ahb(1'b1, `CSP_IX_PTR1H, 8'h01);
      rd(`CSP_IX_PTR1H, 8'h01);
      ahb(1'b1, `CSP_IX_PTR2H, 8'h01);
      ahb(1'b1, `CSP_IX_PORT0, 8'hFF);
      rd(`CSP_IX_PORT0, 8'h00);
      rd(4'hF, 8'h00);
      ahb(1'b1, `CSP_IX_FLAGS, 8'hFF);
      m_fl = 8'hCF;
      rd(`CSP_IX_FLAGS, m_fl);
      for (i = 0; i < 40; i++) op(csp_op_t'($unsigned($random(seed)) % 9 + 1), 8'($random(seed)));
      op(CSP_OP_SUB, m_acc);
      op(CSP_OP_SBC, 8'h00);
      wdt();
      ahb(1'b1, `CSP_IX_FLAGS, 8'h00);
      m_fl = m_fl & 8'h30;
      rd(`CSP_IX_FLAGS, m_fl);
      op(CSP_OP_HALT, 8'h00);
      wdt();
      mv_to_mem <= 1'b1;
      mv_addr <= 9'h00A;
      mv_go <= 1'b1;
      @(posedge mclk);
      mv_go <= 1'b0;
      @(posedge mclk);
      m_fl = (m_acc & `CSP_FLAGS_WMASK) | (m_fl & 8'h30);
      chk("flags_out", {24'h0, m_fl}, {24'h0, flags_out});
      op(CSP_OP_KICK, 8'h00);
      mvt(1'b1, 9'h000, {1'b0, vals[0]});
      mvt(1'b1, 9'h002, {1'b1, vals[1]});
      mvt(1'b1, 9'h00C, {1'b1, vals[2]});
      dm_rdata <= 8'($random(seed));
      mvt(1'b0, 9'h1F0, 9'h1F0);
      m_acc = dm_rdata;
      chk("acc_out", {24'h0, m_acc}, {24'h0, acc_out});
      mvt(1'b1, 9'h1F1, 9'h1F1);
      rd(`CSP_IX_PTR1L, vals[1]);
      ahb(1'b1, `CSP_IX_PCL, vals[2]);
      wt(1);
      chk("pc_jump", 32'h1, {31'h0, pc_jump});
      chk("pc_low", {24'h0, vals[2]}, {24'h0, pc_low});
      @(posedge mclk);
      chk("pc_dummy", 32'h1, {31'h0, pc_dummy});
      tbl_dst <= 9'h1F2;
      tbl_go <= 1'b1;
      @(posedge mclk);
      tbl_go <= 1'b0;
      wt(2);
      chk("pm_req", 32'h1, {31'h0, pm_req});
      chk("pm_addr", {16'h0, vals[5], vals[4]}, {16'h0, pm_addr});
      pm_rdata <= 16'($random(seed));
      pm_valid <= 1'b1;
      @(posedge mclk);
      pm_valid <= 1'b0;
      wt(0);
      chk("pm_req", 32'h0, {31'h0, pm_req});
      chk("dm_addr", 32'h1F2, {23'h0, dm_addr});
      chk("dm_wdata", {24'h0, pm_rdata[7:0]}, {24'h0, dm_wdata});
      rd(`CSP_IX_TABLE_HIGH_LATCH, pm_rdata[15:8]);
      complete_run;
   end
endmodule
